// file: dcmp_host_model.sv
// Host model: peer drives sending frames on both CAN links
`timescale 1ns/1ps
module dcmp_host_model #(
   parameter int PER = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              ext_en_i,
   input  wire logic              int_en_i,
   output dcmp_pkg::dcmp_link_ev_t ext_ev_o,
   output dcmp_pkg::dcmp_link_ev_t int_ev_o
);
   import dcmp_pkg::*;
   logic [7:0] cnt_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_r <= 8'h00;
      else cnt_r <= (cnt_r == 8'(PER - 1)) ? 8'h00 : cnt_r + 8'h01;
   end
   assign ext_ev_o = '{ext_en_i && cnt_r == 8'h00, 1'b0};
   assign int_ev_o = '{int_en_i && cnt_r == 8'h03, 1'b0};
endmodule : dcmp_host_model

// file: dcmp_pkg.sv
// Package: register map, field layouts, reset values, timing and types
package dcmp_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] DCMP_ADR_EXT_RATE   = 8'h00;
   localparam logic [7:0] DCMP_ADR_EXT_NODE   = 8'h04;
   localparam logic [7:0] DCMP_ADR_EXT_LOSS   = 8'h08;
   localparam logic [7:0] DCMP_ADR_SER_CFG    = 8'h0C;
   localparam logic [7:0] DCMP_ADR_SER_ADDR   = 8'h10;
   localparam logic [7:0] DCMP_ADR_SER_DLY    = 8'h14;
   localparam logic [7:0] DCMP_ADR_INT_RATE   = 8'h18;
   localparam logic [7:0] DCMP_ADR_INT_NODE   = 8'h1C;
   localparam logic [7:0] DCMP_ADR_INT_LOSS   = 8'h20;
   localparam logic [7:0] DCMP_ADR_FLOW_TYPE  = 8'h24;
   localparam logic [7:0] DCMP_ADR_SOLE_MST   = 8'h28;
   localparam logic [7:0] DCMP_ADR_UNIT_GRP   = 8'h2C;
   localparam logic [7:0] DCMP_ADR_ROLE_SW    = 8'h30;
   localparam logic [7:0] DCMP_ADR_CUTIN_THR  = 8'h34;
   localparam logic [7:0] DCMP_ADR_CUTIN_HYS  = 8'h38;
   localparam logic [7:0] DCMP_ADR_RUN_SRC    = 8'h3C;
   localparam logic [7:0] DCMP_ADR_FLOW_DMD   = 8'h40;
   localparam logic [7:0] DCMP_ADR_STATUS     = 8'h44;
   localparam logic [7:0] DCMP_ADR_RUN_CMD    = 8'h48;
   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [1:0]  DCMP_EXT_RATE_RST  = 2'h1;
   localparam logic [7:0]  DCMP_EXT_NODE_RST  = 8'h01;
   localparam logic [7:0]  DCMP_EXT_NODE_MAX  = 8'hF7;
   localparam logic [9:0]  DCMP_EXT_LOSS_MAX  = 10'h3E8;
   localparam logic [11:0] DCMP_SER_CFG_RST   = 12'h001;
   localparam logic [11:0] DCMP_SER_CFG_MAX   = 12'h155;
   localparam logic [3:0]  DCMP_SER_BAUD_MAX  = 4'h5;
   localparam logic [3:0]  DCMP_SER_FMT_MAX   = 4'h2;
   localparam logic [6:0]  DCMP_SER_ADDR_RST  = 7'h01;
   localparam logic [13:0] DCMP_SER_DLY_MAX   = 14'h2710;
   localparam logic [1:0]  DCMP_INT_RATE_RST  = 2'h3;
   localparam logic [6:0]  DCMP_INT_NODE_RST  = 7'h00;
   localparam logic [6:0]  DCMP_INT_LOSS_RST  = 7'h05;
   localparam logic [6:0]  DCMP_INT_LOSS_MAX  = 7'h64;
   localparam logic [2:0]  DCMP_UNIT_MAX      = 3'h5;
   localparam logic [9:0]  DCMP_THR_RST       = 10'h190;
   localparam logic [9:0]  DCMP_HYS_RST       = 10'h014;
   localparam logic [9:0]  DCMP_PCT_MAX       = 10'h3E8;
   localparam logic [1:0]  DCMP_RUN_SRC_BUS   = 2'h3;
   // Field positions of the serial config digits
   localparam int DCMP_SER_BAUD_LSB = 0;
   localparam int DCMP_SER_FMT_LSB  = 4;
   // ---------------------------------------------------------------
   // Timing: one tick is 0.1 ms at 40 MHz
   // ---------------------------------------------------------------
   localparam int DCMP_CLK_HZ       = 40000000;
   localparam int DCMP_TICK_US      = 100;
   localparam int DCMP_TICK_CYC     = DCMP_CLK_HZ / 1000000 * DCMP_TICK_US;
   localparam int DCMP_EXT_TICKS_MS = 10;
   localparam int DCMP_INT_TICKS_DS = 1000;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DCMP_CAN_125K, DCMP_CAN_250K, DCMP_CAN_500K, DCMP_CAN_1M
   } dcmp_can_rate_t;
   typedef enum logic [1:0] {
      DCMP_FLOW_SINGLE, DCMP_FLOW_COMPOSITE, DCMP_FLOW_BYPASS,
      DCMP_FLOW_MULTI
   } dcmp_flow_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } dcmp_bus_req_t;
   typedef struct packed {
      logic        rx_frame;
      logic        reply_req;
   } dcmp_link_ev_t;
   typedef struct packed {
      logic        ext_fail;
      logic        int_fail;
      logic        reply_go;
      logic        extra_pumps;
      logic        is_master;
   } dcmp_stat_t;
endpackage : dcmp_pkg

// file: dcmp_top.sv
// Communication and multi-pump configuration with link supervision
// Operation
// - External CAN rate is a two-bit code, default 250K.
// - External CAN node number 0..247, default 1, used as station address.
// - Missing external CAN data over the set interval raises failure.
// - Serial bit rate code 0..5 selects 4800 up to 115200.
// - Serial frame code selects 8N2, 8E1 or 8O1 RTU characters.
// - Serial config digits hold rate and format, limit 0x155, default 001.
// - Drive answers on serial link at local address 0..127, default 1.
// - Serial reply waits configured delay 0.0..1000.0 ms first.
// - Internal CAN rate uses same codes, default 1M.
// - Internal CAN node number 0..127, default 0.
// - No internal CAN data over interval, default 0.5, reports failure.
// - Flow type code selects single, composite, bypass or multi-master.
// - Sole master setting makes drive the network master; only one node.
// - Unit group number 0..5, default 0.
// - Role switch swaps master and slave in multi-master flow.
// - Demand above cut-in threshold, default 40%, starts extra pumps.
// - Hysteresis, default 2 percent, stops start-stop chatter.
// - Run source code 3 takes start and stop from CANopen.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module dcmp_top #(
   parameter int TICK_CYC = dcmp_pkg::DCMP_TICK_CYC
) (
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   ce_i,
   input  wire dcmp_pkg::dcmp_bus_req_t bus_i,
   output logic [31:0]                 rdata_o,
   input  wire dcmp_pkg::dcmp_link_ev_t ext_ev_i,
   input  wire dcmp_pkg::dcmp_link_ev_t int_ev_i,
   input  wire logic                   ser_req_i,
   input  wire logic [6:0]             ser_dst_i,
   input  wire logic                   bus_run_i,
   output dcmp_pkg::dcmp_stat_t        stat_o,
   output logic [1:0]                  ext_rate_o,
   output logic [7:0]                  ext_node_o,
   output logic [1:0]                  int_rate_o,
   output logic [6:0]                  int_node_o,
   output logic [3:0]                  ser_baud_o,
   output logic [3:0]                  ser_fmt_o,
   output logic                        run_o
);
   import dcmp_pkg::*;

   if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_tick_chk
      $error("TICK_CYC must be 1 to 65536");
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [1:0]  ext_rate_r, ext_rate_nxt;
   logic [7:0]  ext_node_r, ext_node_nxt;
   logic [9:0]  ext_loss_r, ext_loss_nxt;
   logic [11:0] ser_cfg_r, ser_cfg_nxt;
   logic [6:0]  ser_addr_r, ser_addr_nxt;
   logic [13:0] ser_dly_r, ser_dly_nxt;
   logic [1:0]  int_rate_r, int_rate_nxt;
   logic [6:0]  int_node_r, int_node_nxt;
   logic [6:0]  int_loss_r, int_loss_nxt;
   logic [1:0]  flow_type_r, flow_type_nxt;
   logic        sole_r, sole_nxt;
   logic [2:0]  unit_r, unit_nxt;
   logic        role_r, role_nxt;
   logic [9:0]  thr_r, thr_nxt;
   logic [9:0]  hys_r, hys_nxt;
   logic [1:0]  run_src_r, run_src_nxt;
   logic [9:0]  dmd_r, dmd_nxt;
   logic        run_cmd_r, run_cmd_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] wd;
   logic [3:0]  wbaud, wfmt;

   always_comb begin
      wd = bus_i.wdata;
      wbaud = wd[DCMP_SER_BAUD_LSB +: 4];
      wfmt = wd[DCMP_SER_FMT_LSB +: 4];
      ext_rate_nxt = ext_rate_r;
      ext_node_nxt = ext_node_r;
      ext_loss_nxt = ext_loss_r;
      ser_cfg_nxt = ser_cfg_r;
      ser_addr_nxt = ser_addr_r;
      ser_dly_nxt = ser_dly_r;
      int_rate_nxt = int_rate_r;
      int_node_nxt = int_node_r;
      int_loss_nxt = int_loss_r;
      flow_type_nxt = flow_type_r;
      sole_nxt = sole_r;
      unit_nxt = unit_r;
      role_nxt = role_r;
      thr_nxt = thr_r;
      hys_nxt = hys_r;
      run_src_nxt = run_src_r;
      dmd_nxt = dmd_r;
      run_cmd_nxt = run_cmd_r;
      if (bus_i.wr) begin
         if (bus_i.addr == DCMP_ADR_EXT_RATE) begin
            ext_rate_nxt = wd[1:0];
         end else if (bus_i.addr == DCMP_ADR_EXT_NODE) begin
            if (wd[7:0] <= DCMP_EXT_NODE_MAX && wd[31:8] == 24'h0)
               ext_node_nxt = wd[7:0];
         end else if (bus_i.addr == DCMP_ADR_EXT_LOSS) begin
            if (wd[9:0] <= DCMP_EXT_LOSS_MAX && wd[31:10] == 22'h0)
               ext_loss_nxt = wd[9:0];
         end else if (bus_i.addr == DCMP_ADR_SER_CFG) begin
            if (wbaud <= DCMP_SER_BAUD_MAX && wfmt <= DCMP_SER_FMT_MAX
                && wd[11:0] <= DCMP_SER_CFG_MAX && wd[31:12] == 20'h0)
               ser_cfg_nxt = wd[11:0];
         end else if (bus_i.addr == DCMP_ADR_SER_ADDR) begin
            ser_addr_nxt = wd[6:0];
         end else if (bus_i.addr == DCMP_ADR_SER_DLY) begin
            if (wd[13:0] <= DCMP_SER_DLY_MAX && wd[31:14] == 18'h0)
               ser_dly_nxt = wd[13:0];
         end else if (bus_i.addr == DCMP_ADR_INT_RATE) begin
            int_rate_nxt = wd[1:0];
         end else if (bus_i.addr == DCMP_ADR_INT_NODE) begin
            int_node_nxt = wd[6:0];
         end else if (bus_i.addr == DCMP_ADR_INT_LOSS) begin
            if (wd[6:0] <= DCMP_INT_LOSS_MAX && wd[31:7] == 25'h0)
               int_loss_nxt = wd[6:0];
         end else if (bus_i.addr == DCMP_ADR_FLOW_TYPE) begin
            flow_type_nxt = wd[1:0];
         end else if (bus_i.addr == DCMP_ADR_SOLE_MST) begin
            sole_nxt = wd[0];
         end else if (bus_i.addr == DCMP_ADR_UNIT_GRP) begin
            if (wd[2:0] <= DCMP_UNIT_MAX && wd[31:3] == 29'h0)
               unit_nxt = wd[2:0];
         end else if (bus_i.addr == DCMP_ADR_ROLE_SW) begin
            role_nxt = wd[0];
         end else if (bus_i.addr == DCMP_ADR_CUTIN_THR) begin
            if (wd[9:0] <= DCMP_PCT_MAX && wd[31:10] == 22'h0)
               thr_nxt = wd[9:0];
         end else if (bus_i.addr == DCMP_ADR_CUTIN_HYS) begin
            if (wd[9:0] <= DCMP_PCT_MAX && wd[31:10] == 22'h0)
               hys_nxt = wd[9:0];
         end else if (bus_i.addr == DCMP_ADR_RUN_SRC) begin
            run_src_nxt = wd[1:0];
         end else if (bus_i.addr == DCMP_ADR_FLOW_DMD) begin
            if (wd[9:0] <= DCMP_PCT_MAX && wd[31:10] == 22'h0)
               dmd_nxt = wd[9:0];
         end else if (bus_i.addr == DCMP_ADR_RUN_CMD) begin
            run_cmd_nxt = wd[0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Tick base and supervision timers
   // ---------------------------------------------------------------
   logic [15:0] pre_r, pre_nxt;
   logic        tick;
   logic [15:0] ext_cnt_r, ext_cnt_nxt;
   logic [16:0] int_cnt_r, int_cnt_nxt;
   logic [13:0] dly_cnt_r, dly_cnt_nxt;
   logic        ext_fail_r, ext_fail_nxt;
   logic        int_fail_r, int_fail_nxt;
   logic        dly_busy_r, dly_busy_nxt;
   logic        go_r, go_nxt;
   logic        extra_r, extra_nxt;
   logic [10:0] lo_lim;
   logic [15:0] ext_lim;
   logic [16:0] int_lim;
   logic        is_master;

   always_comb begin
      tick = (pre_r == 16'(TICK_CYC - 1));
      pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
      ext_lim = 16'(ext_loss_r * DCMP_EXT_TICKS_MS);
      int_lim = 17'(int_loss_r * DCMP_INT_TICKS_DS);
      // Data resets the watchdog; zero interval disables it
      ext_cnt_nxt = ext_cnt_r;
      ext_fail_nxt = ext_fail_r;
      if (ext_ev_i.rx_frame || ext_loss_r == 10'h000) begin
         ext_cnt_nxt = 16'h0000;
         ext_fail_nxt = 1'b0;
      end else if (tick) begin
         if (ext_cnt_r + 16'h0001 >= ext_lim)
            ext_fail_nxt = 1'b1;
         else
            ext_cnt_nxt = ext_cnt_r + 16'h0001;
      end
      int_cnt_nxt = int_cnt_r;
      int_fail_nxt = int_fail_r;
      if (int_ev_i.rx_frame || int_loss_r == 7'h00) begin
         int_cnt_nxt = 17'h00000;
         int_fail_nxt = 1'b0;
      end else if (tick) begin
         if (int_cnt_r + 17'h00001 >= int_lim)
            int_fail_nxt = 1'b1;
         else
            int_cnt_nxt = int_cnt_r + 17'h00001;
      end
      // Reply only to own address, after the delay
      go_nxt = 1'b0;
      dly_cnt_nxt = dly_cnt_r;
      dly_busy_nxt = dly_busy_r;
      if (!dly_busy_r) begin
         if (ser_req_i && ser_dst_i == ser_addr_r) begin
            dly_busy_nxt = 1'b1;
            dly_cnt_nxt = 14'h0000;
         end
      end else if (dly_cnt_r >= ser_dly_r) begin
         go_nxt = 1'b1;
         dly_busy_nxt = 1'b0;
      end else if (tick) begin
         dly_cnt_nxt = dly_cnt_r + 14'h0001;
      end
      // Cut-in with hysteresis band
      lo_lim = {1'b0, thr_r} - {1'b0, hys_r};
      extra_nxt = extra_r;
      if (flow_type_r == DCMP_FLOW_SINGLE)
         extra_nxt = 1'b0;
      else if (dmd_r > thr_r)
         extra_nxt = 1'b1;
      else if (lo_lim[10] || {1'b0, dmd_r} < lo_lim)
         extra_nxt = 1'b0;
      // Role: sole master wins, role switch only in multi-master flow
      if (sole_r)
         is_master = 1'b1;
      else if (flow_type_r == DCMP_FLOW_MULTI)
         is_master = role_r;
      else
         is_master = 1'b0;
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (bus_i.rd) begin
         if (bus_i.addr == DCMP_ADR_EXT_RATE)
            rdata_nxt[1:0] = ext_rate_r;
         else if (bus_i.addr == DCMP_ADR_EXT_NODE)
            rdata_nxt[7:0] = ext_node_r;
         else if (bus_i.addr == DCMP_ADR_EXT_LOSS)
            rdata_nxt[9:0] = ext_loss_r;
         else if (bus_i.addr == DCMP_ADR_SER_CFG)
            rdata_nxt[11:0] = ser_cfg_r;
         else if (bus_i.addr == DCMP_ADR_SER_ADDR)
            rdata_nxt[6:0] = ser_addr_r;
         else if (bus_i.addr == DCMP_ADR_SER_DLY)
            rdata_nxt[13:0] = ser_dly_r;
         else if (bus_i.addr == DCMP_ADR_INT_RATE)
            rdata_nxt[1:0] = int_rate_r;
         else if (bus_i.addr == DCMP_ADR_INT_NODE)
            rdata_nxt[6:0] = int_node_r;
         else if (bus_i.addr == DCMP_ADR_INT_LOSS)
            rdata_nxt[6:0] = int_loss_r;
         else if (bus_i.addr == DCMP_ADR_FLOW_TYPE)
            rdata_nxt[1:0] = flow_type_r;
         else if (bus_i.addr == DCMP_ADR_SOLE_MST)
            rdata_nxt[0] = sole_r;
         else if (bus_i.addr == DCMP_ADR_UNIT_GRP)
            rdata_nxt[2:0] = unit_r;
         else if (bus_i.addr == DCMP_ADR_ROLE_SW)
            rdata_nxt[0] = role_r;
         else if (bus_i.addr == DCMP_ADR_CUTIN_THR)
            rdata_nxt[9:0] = thr_r;
         else if (bus_i.addr == DCMP_ADR_CUTIN_HYS)
            rdata_nxt[9:0] = hys_r;
         else if (bus_i.addr == DCMP_ADR_RUN_SRC)
            rdata_nxt[1:0] = run_src_r;
         else if (bus_i.addr == DCMP_ADR_FLOW_DMD)
            rdata_nxt[9:0] = dmd_r;
         else if (bus_i.addr == DCMP_ADR_STATUS)
            rdata_nxt[4:0] = {ext_fail_r, int_fail_r, dly_busy_r,
                              extra_r, is_master};
         else if (bus_i.addr == DCMP_ADR_RUN_CMD)
            rdata_nxt[0] = run_cmd_r;
      end
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_rate_r <= DCMP_EXT_RATE_RST;
         ext_node_r <= DCMP_EXT_NODE_RST;
         ext_loss_r <= 10'h000;
         ser_cfg_r <= DCMP_SER_CFG_RST;
         ser_addr_r <= DCMP_SER_ADDR_RST;
         ser_dly_r <= 14'h0000;
         int_rate_r <= DCMP_INT_RATE_RST;
         int_node_r <= DCMP_INT_NODE_RST;
         int_loss_r <= DCMP_INT_LOSS_RST;
         flow_type_r <= 2'h0;
         sole_r <= 1'b0;
         unit_r <= 3'h0;
         role_r <= 1'b0;
         thr_r <= DCMP_THR_RST;
         hys_r <= DCMP_HYS_RST;
         run_src_r <= 2'h0;
         dmd_r <= 10'h000;
         run_cmd_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         pre_r <= 16'h0000;
         ext_cnt_r <= 16'h0000;
         int_cnt_r <= 17'h00000;
         dly_cnt_r <= 14'h0000;
         ext_fail_r <= 1'b0;
         int_fail_r <= 1'b0;
         dly_busy_r <= 1'b0;
         go_r <= 1'b0;
         extra_r <= 1'b0;
      end else if (ce_i) begin
         ext_rate_r <= ext_rate_nxt;
         ext_node_r <= ext_node_nxt;
         ext_loss_r <= ext_loss_nxt;
         ser_cfg_r <= ser_cfg_nxt;
         ser_addr_r <= ser_addr_nxt;
         ser_dly_r <= ser_dly_nxt;
         int_rate_r <= int_rate_nxt;
         int_node_r <= int_node_nxt;
         int_loss_r <= int_loss_nxt;
         flow_type_r <= flow_type_nxt;
         sole_r <= sole_nxt;
         unit_r <= unit_nxt;
         role_r <= role_nxt;
         thr_r <= thr_nxt;
         hys_r <= hys_nxt;
         run_src_r <= run_src_nxt;
         dmd_r <= dmd_nxt;
         run_cmd_r <= run_cmd_nxt;
         rdata_r <= rdata_nxt;
         pre_r <= pre_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         int_cnt_r <= int_cnt_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         ext_fail_r <= ext_fail_nxt;
         int_fail_r <= int_fail_nxt;
         dly_busy_r <= dly_busy_nxt;
         go_r <= go_nxt;
         extra_r <= extra_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign rdata_o = rdata_r;
   assign stat_o = '{ext_fail: ext_fail_r, int_fail: int_fail_r,
                     reply_go: go_r, extra_pumps: extra_r,
                     is_master: is_master};
   assign ext_rate_o = ext_rate_r;
   assign ext_node_o = ext_node_r;
   assign int_rate_o = int_rate_r;
   assign int_node_o = int_node_r;
   assign ser_baud_o = ser_cfg_r[DCMP_SER_BAUD_LSB +: 4];
   assign ser_fmt_o = ser_cfg_r[DCMP_SER_FMT_LSB +: 4];
   assign run_o = (run_src_r == DCMP_RUN_SRC_BUS) ? bus_run_i
                                                  : run_cmd_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_own_req;
      ce_i && !dly_busy_r && ser_req_i && ser_dst_i == ser_addr_r
      && ser_dly_r == 14'h0000;
   endsequence
   a_cutin_rise: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && flow_type_r != DCMP_FLOW_SINGLE && dmd_r > thr_r |=> extra_r)
      else $error("extra pumps not started above threshold");
   a_release_band: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      $fell(extra_r) |-> $past(flow_type_r) == DCMP_FLOW_SINGLE
         || $past(lo_lim[10]) || {1'b0, $past(dmd_r)} < $past(lo_lim))
      else $error("extra pumps released inside band");
   a_sole_master: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      sole_r |-> is_master)
      else $error("sole master not master");
   a_reply_addr: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(dly_busy_r) |-> $past(ser_dst_i) == ser_addr_r)
      else $error("reply started for foreign address");
   a_reply_zero: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      s_own_req ##1 ce_i |=> go_r)
      else $error("zero delay reply late");
   a_ser_limit: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ser_cfg_r <= DCMP_SER_CFG_MAX && ser_fmt_o <= DCMP_SER_FMT_MAX)
      else $error("serial config out of range");
   a_ext_node_rng: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ext_node_r <= DCMP_EXT_NODE_MAX)
      else $error("node number out of range");
   a_ext_clear: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && ext_ev_i.rx_frame |=> !ext_fail_r)
      else $error("ext failure kept after data");
   a_bus_run: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      run_src_r == DCMP_RUN_SRC_BUS |-> run_o == bus_run_i)
      else $error("bus run source ignored");
endmodule : dcmp_top

// file: test_dcmp_top.sv
// Testbench: register port, serial reply, pump cut-in, watchdogs
`timescale 1ns/1ps
module test_dcmp_top;
   import dcmp_pkg::*;
   logic          clk_i = 0, rstn_i = 0, ser_req_i = 0;
   logic          bus_run_i = 0, xe = 1, ie = 1, run_o;
   logic [6:0]    ser_dst_i = 7'h00, int_node_o;
   logic [1:0]    ext_rate_o, int_rate_o;
   logic [7:0]    ext_node_o;
   logic [3:0]    ser_baud_o, ser_fmt_o;
   logic [31:0]   rdata_o;
   dcmp_bus_req_t bus_i = '0;
   dcmp_link_ev_t ext_ev, int_ev;
   dcmp_stat_t    stat_o;
   int            err_total = 0, n_compared = 0;
   always #12.5 clk_i = ~clk_i;
   dcmp_top #(.TICK_CYC(2)) u_dcmp_top (.clk_i(clk_i), .rstn_i(rstn_i),
      .ce_i(1'b1), .bus_i(bus_i), .rdata_o(rdata_o), .ext_ev_i(ext_ev),
      .int_ev_i(int_ev), .ser_req_i(ser_req_i), .ser_dst_i(ser_dst_i),
      .bus_run_i(bus_run_i), .stat_o(stat_o), .ext_rate_o(ext_rate_o),
      .ext_node_o(ext_node_o), .int_rate_o(int_rate_o),
      .int_node_o(int_node_o), .ser_baud_o(ser_baud_o),
      .ser_fmt_o(ser_fmt_o), .run_o(run_o));
   dcmp_host_model u_dcmp_host_model (.clk_i(clk_i), .rstn_i(rstn_i),
      .ext_en_i(xe), .int_en_i(ie), .ext_ev_o(ext_ev), .int_ev_o(int_ev));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got %0h exp %0h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i) bus_i <= '0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i) bus_i <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_i) bus_i <= '0;
      #1 chk(rdata_o, e);
   endtask : rd
   task automatic ser(input logic [6:0] d, input logic e);
      logic s;
      s = 1'b0;
      @(posedge clk_i) ser_req_i <= 1'b1;
      ser_dst_i <= d;
      @(posedge clk_i) ser_req_i <= 1'b0;
      repeat (6) begin
         @(posedge clk_i) #1 s = s | stat_o.reply_go;
      end
      chk(32'(s), 32'(e));
   endtask : ser
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      #(25 * 20000) err_total++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i) #1 chk(32'(ext_rate_o), 32'h1);
      chk(32'(ext_node_o), 32'h1);
      chk(32'(int_rate_o), 32'h3);
      chk(32'(int_node_o), 32'h0);
      chk(32'({ser_fmt_o, ser_baud_o}), 32'h01);
      rd(DCMP_ADR_CUTIN_THR, 32'h190);
      rd(DCMP_ADR_CUTIN_HYS, 32'h14);
      ser(7'h01, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(DCMP_ADR_EXT_RATE, 32'(i));
         chk(32'(ext_rate_o), 32'(i));
         wr(DCMP_ADR_INT_RATE, 32'(i));
         chk(32'(int_rate_o), 32'(i));
      end
      wr(DCMP_ADR_EXT_NODE, 32'hF7);
      wr(DCMP_ADR_EXT_NODE, 32'hF8);
      chk(32'(ext_node_o), 32'hF7);
      wr(DCMP_ADR_INT_NODE, 32'h7F);
      chk(32'(int_node_o), 32'h7F);
      wr(DCMP_ADR_UNIT_GRP, 32'h5);
      wr(DCMP_ADR_UNIT_GRP, 32'h6);
      rd(DCMP_ADR_UNIT_GRP, 32'h5);
      for (int b = 0; b < 6; b++)
         for (int f = 0; f < 3; f++) begin
            wr(DCMP_ADR_SER_CFG, 32'(f * 16 + b));
            chk(32'({ser_fmt_o, ser_baud_o}), 32'(f * 16 + b));
         end
      wr(DCMP_ADR_SER_CFG, 32'h156);
      rd(DCMP_ADR_SER_CFG, 32'h025);
      wr(DCMP_ADR_SER_ADDR, 32'h7F);
      ser(7'h7F, 1'b1);
      ser(7'h05, 1'b0);
      wr(DCMP_ADR_SER_DLY, 32'h5);
      ser(7'h7F, 1'b0);
      ser(7'h7F, 1'b1);
      wr(DCMP_ADR_FLOW_TYPE, 32'h1);
      wr(DCMP_ADR_FLOW_DMD, 32'h190);
      rd(DCMP_ADR_STATUS, 32'h0);
      wr(DCMP_ADR_FLOW_DMD, 32'h191);
      rd(DCMP_ADR_STATUS, 32'h2);
      chk(32'(stat_o.extra_pumps), 32'h1);
      wr(DCMP_ADR_FLOW_DMD, 32'h17C);
      rd(DCMP_ADR_STATUS, 32'h2);
      wr(DCMP_ADR_FLOW_DMD, 32'h17B);
      rd(DCMP_ADR_STATUS, 32'h0);
      wr(DCMP_ADR_FLOW_DMD, 32'h191);
      wr(DCMP_ADR_FLOW_TYPE, 32'h0);
      rd(DCMP_ADR_STATUS, 32'h0);
      wr(DCMP_ADR_FLOW_DMD, 32'h0);
      wr(DCMP_ADR_SOLE_MST, 32'h1);
      rd(DCMP_ADR_STATUS, 32'h1);
      chk(32'(stat_o.is_master), 32'h1);
      wr(DCMP_ADR_SOLE_MST, 32'h0);
      wr(DCMP_ADR_FLOW_TYPE, 32'h3);
      wr(DCMP_ADR_ROLE_SW, 32'h1);
      rd(DCMP_ADR_STATUS, 32'h1);
      wr(DCMP_ADR_FLOW_TYPE, 32'h2);
      rd(DCMP_ADR_STATUS, 32'h0);
      wr(DCMP_ADR_RUN_SRC, 32'h3);
      @(posedge clk_i) bus_run_i <= 1'b1;
      #1 chk(32'(run_o), 32'h1);
      wr(DCMP_ADR_RUN_SRC, 32'h0);
      chk(32'(run_o), 32'h0);
      wr(DCMP_ADR_RUN_CMD, 32'h1);
      chk(32'(run_o), 32'h1);
      rd(8'hFC, 32'h0);
      @(posedge clk_i) xe <= 1'b0;
      wr(DCMP_ADR_EXT_LOSS, 32'h1);
      repeat (10) @(posedge clk_i);
      #1 chk(32'(stat_o.ext_fail), 32'h0);
      repeat (20) @(posedge clk_i);
      #1 chk(32'(stat_o.ext_fail), 32'h1);
      @(posedge clk_i) xe <= 1'b1;
      repeat (12) @(posedge clk_i);
      #1 chk(32'(stat_o.ext_fail), 32'h0);
      @(posedge clk_i) ie <= 1'b0;
      repeat (9000) @(posedge clk_i);
      #1 chk(32'(stat_o.int_fail), 32'h0);
      repeat (1100) @(posedge clk_i);
      #1 chk(32'(stat_o.int_fail), 32'h1);
      end_of_test();
   end
endmodule : test_dcmp_top
